// *** hw/line_state_condition_latch.sv ***
`timescale 1ns/1ps
`default_nettype none
module line_state_condition_latch (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clockEnable,
  input wire logic [line_state_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [line_state_pkg::DATA_W-1:0] wdata,
  input wire logic [line_state_pkg::STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [line_state_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [line_state_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic signal_detect_input,
  input wire logic quietDetect,
  input wire logic haltDetect,
  input wire logic masterDetect,
  input wire logic noiseDetect,
  input wire logic otherKnownDetect,
  input wire logic noiseCounterZero,
  input wire logic [line_state_pkg::REG_W-1:0] historyBEvents,
  output logic [line_state_pkg::REG_W-1:0] noiseThreshold,
  output logic [line_state_pkg::REG_W-1:0] noisePrescaleThreshold,
  output logic interruptRequest
);
  import line_state_pkg::*;

  // ********************************************************************
  // Line state tracking
  // ********************************************************************
  logic [NUM_COND-1:0] cond;
  logic [NUM_COND-1:0] condPrev;
  logic [NUM_COND-1:0] next_condPrev;
  logic [NUM_COND-1:0] entered;
  logic unknownNow;
  logic unknownPrev;
  logic next_unknownPrev;
  logic noiseZeroPrev;
  logic next_noiseZeroPrev;
  line_class_t lastClass;
  line_class_t next_lastClass;
  logic unknownEntry;
  logic unknownInvalidEntry;
  logic changeEntry;
  logic noiseZeroEntry;

  assign cond[BIT_NO_SIGNAL] = ~signal_detect_input;
  assign cond[BIT_QUIET] = quietDetect;
  assign cond[BIT_HALT] = haltDetect;
  assign cond[BIT_MASTER] = masterDetect;
  assign cond[BIT_NOISE] = noiseDetect;
  assign cond[COND_OTHER] = otherKnownDetect;
  assign unknownNow = ~(|cond);
  // Only rising conditions count, so a state held across a clear does
  // not immediately set its bit again.
  assign entered = cond & ~condPrev;
  assign unknownEntry = unknownNow & ~unknownPrev;
  assign unknownInvalidEntry = unknownEntry &
    (lastClass == CLASS_INVALIDATING);
  assign changeEntry = (|entered) | unknownEntry;
  assign noiseZeroEntry = noiseCounterZero & ~noiseZeroPrev;

  always_comb
  begin
    next_condPrev = cond;
    next_unknownPrev = unknownNow;
    next_noiseZeroPrev = noiseCounterZero;
    next_lastClass = lastClass;
    if (|cond[NUM_INVALIDATING-1:0])
    begin
      next_lastClass = CLASS_INVALIDATING;
    end
    else if (cond[COND_OTHER])
    begin
      next_lastClass = CLASS_OTHER;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      condPrev <= ZERO_COND;
      unknownPrev <= 1'b1;
      noiseZeroPrev <= 1'b0;
      lastClass <= CLASS_NONE;
    end
    else if (clockEnable)
    begin
      condPrev <= next_condPrev;
      unknownPrev <= next_unknownPrev;
      noiseZeroPrev <= next_noiseZeroPrev;
      lastClass <= next_lastClass;
    end
  end

  // ********************************************************************
  // AXI4-Lite slave
  // ********************************************************************
  logic awHeld;
  logic wHeld;
  logic [ADDR_W-1:0] awAddrReg;
  logic [DATA_W-1:0] wDataReg;
  logic [STRB_W-1:0] wStrbReg;
  logic next_awHeld;
  logic next_wHeld;
  logic [ADDR_W-1:0] next_awAddrReg;
  logic [DATA_W-1:0] next_wDataReg;
  logic [STRB_W-1:0] next_wStrbReg;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [1:0] next_rresp;
  logic [DATA_W-1:0] next_rdata;
  logic [DATA_W-1:0] readWord;
  logic writeFire;
  logic readFire;
  logic writeLow;
  reg_index_t wrIdx;
  reg_index_t rdIdx;
  logic rdMapped;

  // Ready drops with the clock enable so no beat is taken while frozen
  assign awready = clockEnable & ~awHeld & ~bvalid;
  assign wready = clockEnable & ~wHeld & ~bvalid;
  assign arready = clockEnable & ~rvalid;
  assign writeFire = clockEnable & awHeld & wHeld & ~bvalid;
  assign readFire = arvalid & arready;
  assign wrIdx = regIndex(awAddrReg);
  assign rdIdx = regIndex(araddr);
  assign rdMapped = isMapped(rdIdx);
  // Registers are one byte wide; only lane 0 carries them
  assign writeLow = writeFire & isMapped(wrIdx) & wStrbReg[0];

  always_comb
  begin
    next_awHeld = awHeld;
    next_wHeld = wHeld;
    next_awAddrReg = awAddrReg;
    next_wDataReg = wDataReg;
    next_wStrbReg = wStrbReg;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (awvalid && awready)
    begin
      next_awHeld = 1'b1;
      next_awAddrReg = awaddr;
    end
    if (wvalid && wready)
    begin
      next_wHeld = 1'b1;
      next_wDataReg = wdata;
      next_wStrbReg = wstrb;
    end
    if (writeFire)
    begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = isMapped(wrIdx) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid && bready)
    begin
      next_bvalid = 1'b0;
    end
    if (readFire)
    begin
      next_rvalid = 1'b1;
      next_rresp = isMapped(rdIdx) ? RESP_OKAY : RESP_SLVERR;
      next_rdata = readWord;
    end
    else if (rvalid && rready)
    begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrReg <= ZERO_ADDR;
      wDataReg <= ZERO_WORD;
      wStrbReg <= ZERO_STRB;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= ZERO_WORD;
    end
    else if (clockEnable)
    begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awAddrReg <= next_awAddrReg;
      wDataReg <= next_wDataReg;
      wStrbReg <= next_wStrbReg;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // ********************************************************************
  // History registers
  // ********************************************************************
  history_if histA ();
  history_if histB ();
  logic noiseLoad;
  logic [REG_W-1:0] wByte;

  assign wByte = wDataReg[REG_W-1:0];
  // Only a nonzero threshold load rearms the noise expiry flag
  assign noiseLoad = writeLow & (wByte != ZERO_BYTE) &
    (wrIdx == IDX_NOISE_THR || wrIdx == IDX_NOISE_PRE);

  assign histA.setEvents = {unknownInvalidEntry, changeEntry,
    noiseZeroEntry, entered[NUM_INVALIDATING-1:0]};
  assign histA.hwClear = noiseLoad ? NT_ONLY : ZERO_BYTE;
  assign histA.swClearable = ~NT_ONLY;
  assign histA.writeData = wByte;
  assign histA.writeStrobe = writeLow & (wrIdx == IDX_HIST_A);
  assign histA.readStrobe = readFire & (rdIdx == IDX_HIST_A);

  assign histB.setEvents = historyBEvents;
  assign histB.hwClear = ZERO_BYTE;
  assign histB.swClearable = ~ZERO_BYTE;
  assign histB.writeData = wByte;
  assign histB.writeStrobe = writeLow & (wrIdx == IDX_HIST_B);
  assign histB.readStrobe = readFire & (rdIdx == IDX_HIST_B);

  // Reset value carries the expired noise flag: the counter starts at 0
  line_state_history #(.RESET_VALUE(HIST_A_RESET)) u_histA (
    .clock(clock),
    .sys_rst(sys_rst),
    .clockEnable(clockEnable),
    .hist(histA.owner)
  );

  line_state_history #(.RESET_VALUE(HIST_B_RESET)) u_histB (
    .clock(clock),
    .sys_rst(sys_rst),
    .clockEnable(clockEnable),
    .hist(histB.owner)
  );

  // ********************************************************************
  // Masks, summary, interrupt and thresholds
  // ********************************************************************
  logic [REG_W-1:0] maskA;
  logic [REG_W-1:0] maskB;
  logic [NUM_SUMMARY-1:0] summary;
  logic [NUM_SUMMARY-1:0] irqStatus;
  logic [NUM_SUMMARY-1:0] irqMask;
  logic [REG_W-1:0] next_maskA;
  logic [REG_W-1:0] next_maskB;
  logic [NUM_SUMMARY-1:0] next_irqStatus;
  logic [NUM_SUMMARY-1:0] next_irqMask;
  logic [REG_W-1:0] next_noiseThreshold;
  logic [REG_W-1:0] next_noisePrescale;

  assign summary[SUM_A_BIT] = |(histA.history & maskA);
  assign summary[SUM_B_BIT] = |(histB.history & maskB);
  assign interruptRequest = |(irqStatus & irqMask);

  always_comb
  begin
    next_maskA = maskA;
    next_maskB = maskB;
    next_irqMask = irqMask;
    next_irqStatus = irqStatus;
    next_noiseThreshold = noiseThreshold;
    next_noisePrescale = noisePrescaleThreshold;
    if (writeLow)
    begin
      unique case (wrIdx)
        IDX_MASK_A: next_maskA = wByte;
        IDX_MASK_B: next_maskB = wByte;
        IDX_IRQ_MASK: next_irqMask = wByte[NUM_SUMMARY-1:0];
        IDX_IRQ_STATUS: next_irqStatus = irqStatus &
          ~wByte[NUM_SUMMARY-1:0];
        IDX_NOISE_THR: next_noiseThreshold = wByte;
        IDX_NOISE_PRE: next_noisePrescale = wByte;
        default: next_maskA = maskA;
      endcase
    end
    // Set after clear: a live summary is never lost to a clear
    next_irqStatus = next_irqStatus | summary;
  end

  always_comb
  begin
    readWord = ZERO_WORD;
    unique case (rdIdx)
      IDX_SUMMARY: readWord = widen({{(REG_W-NUM_SUMMARY){1'b0}}, summary});
      IDX_IRQ_STATUS:
        readWord = widen({{(REG_W-NUM_SUMMARY){1'b0}}, irqStatus});
      IDX_IRQ_MASK:
        readWord = widen({{(REG_W-NUM_SUMMARY){1'b0}}, irqMask});
      IDX_HIST_A: readWord = widen(histA.history);
      IDX_HIST_B: readWord = widen(histB.history);
      IDX_MASK_A: readWord = widen(maskA);
      IDX_MASK_B: readWord = widen(maskB);
      IDX_NOISE_THR: readWord = widen(noiseThreshold);
      IDX_NOISE_PRE: readWord = widen(noisePrescaleThreshold);
      default: readWord = ZERO_WORD;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      maskA <= ZERO_BYTE;
      maskB <= ZERO_BYTE;
      irqStatus <= ZERO_SUMMARY;
      irqMask <= ZERO_SUMMARY;
      noiseThreshold <= ZERO_BYTE;
      noisePrescaleThreshold <= ZERO_BYTE;
    end
    else if (clockEnable)
    begin
      maskA <= next_maskA;
      maskB <= next_maskB;
      irqStatus <= next_irqStatus;
      irqMask <= next_irqMask;
      noiseThreshold <= next_noiseThreshold;
      noisePrescaleThreshold <= next_noisePrescale;
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  property p_summaryA;
    @(posedge clock) disable iff (sys_rst)
    (clockEnable && (histA.history & maskA) != ZERO_BYTE) |=>
      irqStatus[SUM_A_BIT];
  endproperty
  a_summaryA: assert property (p_summaryA)
    else $error("summary A did not reach interrupt status");

  property p_summaryFalls;
    @(posedge clock) disable iff (sys_rst)
    (readFire && rdIdx == IDX_SUMMARY &&
      (histB.history & maskB) == ZERO_BYTE) |=> !rdata[SUM_B_BIT];
  endproperty
  a_summaryFalls: assert property (p_summaryFalls)
    else $error("summary B high without enabled history bit");

  property p_noSignal;
    @(posedge clock) disable iff (sys_rst)
    (clockEnable && $fell(signal_detect_input) &&
      !condPrev[BIT_NO_SIGNAL]) |=> histA.history[BIT_NO_SIGNAL];
  endproperty
  a_noSignal: assert property (p_noSignal)
    else $error("no-signal bit not set");

  property p_masterEntry;
    @(posedge clock) disable iff (sys_rst)
    (clockEnable && masterDetect && !condPrev[BIT_MASTER]) |=>
      histA.history[BIT_MASTER] && histA.history[BIT_CHANGE];
  endproperty
  a_masterEntry: assert property (p_masterEntry)
    else $error("master entry not recorded with change");

  property p_ntReset;
    @(posedge clock) disable iff (sys_rst)
    $fell(sys_rst) |-> histA.history[BIT_NOISE_EXPIRED];
  endproperty
  a_ntReset: assert property (p_ntReset)
    else $error("noise expiry flag clear after reset");

  property p_ntClear;
    @(posedge clock) disable iff (sys_rst)
    (noiseLoad && !noiseZeroEntry) |=> !histA.history[BIT_NOISE_EXPIRED];
  endproperty
  a_ntClear: assert property (p_ntClear)
    else $error("noise expiry flag not cleared by threshold load");

  property p_ntHold;
    @(posedge clock) disable iff (sys_rst)
    (histA.history[BIT_NOISE_EXPIRED] && !noiseLoad) |=>
      histA.history[BIT_NOISE_EXPIRED];
  endproperty
  a_ntHold: assert property (p_ntHold)
    else $error("noise expiry flag dropped without load");

  property p_unknownInvalid;
    @(posedge clock) disable iff (sys_rst)
    (clockEnable && $fell(noiseDetect) && unknownNow && !unknownPrev) |=>
      histA.history[BIT_UNKNOWN_INVALID];
  endproperty
  a_unknownInvalid: assert property (p_unknownInvalid)
    else $error("unknown-invalid bit not set after noise");

  property p_readAnswer;
    @(posedge clock) disable iff (sys_rst)
    readFire |=> rvalid && rresp == ($past(rdMapped) ? RESP_OKAY :
      RESP_SLVERR);
  endproperty
  a_readAnswer: assert property (p_readAnswer)
    else $error("read not answered next cycle");

  property p_irqLevel;
    @(posedge clock) disable iff (sys_rst)
    (clockEnable && (summary & irqMask) != ZERO_SUMMARY) |=>
      interruptRequest;
  endproperty
  a_irqLevel: assert property (p_irqLevel)
    else $error("interrupt level disagrees with status and mask");

  c_summaryA: cover property (@(posedge clock) disable iff (sys_rst)
    $rose(summary[SUM_A_BIT]));
  c_irq: cover property (@(posedge clock) disable iff (sys_rst)
    $rose(interruptRequest));
  c_histWrite: cover property (@(posedge clock) disable iff (sys_rst)
    histA.writeStrobe ##[1:20] histA.readStrobe);
  c_unknownInvalid: cover property (@(posedge clock) disable iff (sys_rst)
    unknownInvalidEntry && clockEnable);

endmodule : line_state_condition_latch
`default_nettype wire

// *** hw/line_state_pkg.sv ***
package line_state_pkg;

  // ********************************************************************
  // Widths
  // ********************************************************************
  localparam int REG_W = 8;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int IDX_W = ADDR_W - 2;
  localparam int STRB_W = DATA_W / 8;
  typedef logic [IDX_W-1:0] reg_index_t;

  // ********************************************************************
  // Register indices (byte address is four times the index)
  // ********************************************************************
  localparam reg_index_t IDX_SUMMARY = 6'h02;
  localparam reg_index_t IDX_IRQ_STATUS = 6'h03;
  localparam reg_index_t IDX_IRQ_MASK = 6'h04;
  localparam reg_index_t IDX_HIST_A = 6'h09;
  localparam reg_index_t IDX_HIST_B = 6'h0A;
  localparam reg_index_t IDX_MASK_A = 6'h0B;
  localparam reg_index_t IDX_MASK_B = 6'h0C;
  localparam reg_index_t IDX_NOISE_THR = 6'h0D;
  localparam reg_index_t IDX_NOISE_PRE = 6'h0E;

  // ********************************************************************
  // Field positions
  // ********************************************************************
  localparam int BIT_NO_SIGNAL = 0;
  localparam int BIT_QUIET = 1;
  localparam int BIT_HALT = 2;
  localparam int BIT_MASTER = 3;
  localparam int BIT_NOISE = 4;
  localparam int BIT_NOISE_EXPIRED = 5;
  localparam int BIT_CHANGE = 6;
  localparam int BIT_UNKNOWN_INVALID = 7;
  localparam int NUM_COND = 6;
  localparam int COND_OTHER = 5;
  localparam int NUM_INVALIDATING = 5;
  localparam int SUM_A_BIT = 0;
  localparam int SUM_B_BIT = 1;
  localparam int NUM_SUMMARY = 2;

  // ********************************************************************
  // Reset values and bus answers
  // ********************************************************************
  localparam logic [REG_W-1:0] HIST_A_RESET = 8'h20;
  localparam logic [REG_W-1:0] HIST_B_RESET = 8'h00;
  localparam logic [REG_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [REG_W-1:0] NT_ONLY = 8'h20;
  localparam logic [NUM_SUMMARY-1:0] ZERO_SUMMARY = 2'h0;
  localparam logic [NUM_COND-1:0] ZERO_COND = 6'h00;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] ZERO_ADDR = 8'h00;
  localparam logic [STRB_W-1:0] ZERO_STRB = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {CLASS_NONE, CLASS_INVALIDATING, CLASS_OTHER}
    line_class_t;

  function automatic reg_index_t regIndex(input logic [ADDR_W-1:0] addr);
    return addr[ADDR_W-1:2];
  endfunction : regIndex

  function automatic logic isMapped(input reg_index_t idx);
    return idx inside {IDX_SUMMARY, IDX_IRQ_STATUS, IDX_IRQ_MASK,
      IDX_HIST_A, IDX_HIST_B, IDX_MASK_A, IDX_MASK_B, IDX_NOISE_THR,
      IDX_NOISE_PRE};
  endfunction : isMapped

  function automatic logic [DATA_W-1:0] widen(input logic [REG_W-1:0] v);
    return {{(DATA_W-REG_W){1'b0}}, v};
  endfunction : widen

endpackage : line_state_pkg

// *** hw/history_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface history_if;
  import line_state_pkg::*;
  logic [REG_W-1:0] setEvents;
  logic [REG_W-1:0] hwClear;
  logic [REG_W-1:0] swClearable;
  logic [REG_W-1:0] writeData;
  logic writeStrobe;
  logic readStrobe;
  logic [REG_W-1:0] history;
  modport owner(input setEvents, hwClear, swClearable, writeData,
    writeStrobe, readStrobe, output history);
  modport user(output setEvents, hwClear, swClearable, writeData,
    writeStrobe, readStrobe, input history);
endinterface : history_if
`default_nettype wire

// *** hw/line_state_history.sv ***
`timescale 1ns/1ps
`default_nettype none
module line_state_history #(
  parameter logic [line_state_pkg::REG_W-1:0] RESET_VALUE = 8'h00
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clockEnable,
  history_if.owner hist
);
  import line_state_pkg::*;

  logic [REG_W-1:0] fresh;
  logic [REG_W-1:0] next_history;
  logic [REG_W-1:0] next_fresh;
  logic [REG_W-1:0] clearable;

  // ********************************************************************
  // Sticky history with guarded clear
  // ********************************************************************
  // A bit set after the last read is protected, so software cannot
  // wipe an event it has never seen.
  always_comb
  begin
    next_history = hist.history;
    next_fresh = fresh;
    clearable = ~hist.writeData & ~fresh & hist.swClearable;
    if (hist.readStrobe)
    begin
      next_fresh = ZERO_BYTE;
    end
    if (hist.writeStrobe)
    begin
      next_history = next_history & ~clearable;
    end
    next_history = next_history & ~hist.hwClear;
    next_history = next_history | hist.setEvents;
    next_fresh = next_fresh | hist.setEvents;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hist.history <= RESET_VALUE;
      fresh <= ZERO_BYTE;
    end
    else if (clockEnable)
    begin
      hist.history <= next_history;
      fresh <= next_fresh;
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  property p_setSticky;
    @(posedge clock) disable iff (sys_rst)
    clockEnable |=> ((hist.history & $past(hist.setEvents)) ==
      $past(hist.setEvents));
  endproperty
  a_setSticky: assert property (p_setSticky)
    else $error("history bit not set by event");

  property p_noSelfClear;
    @(posedge clock) disable iff (sys_rst)
    (clockEnable && !hist.writeStrobe && hist.hwClear == ZERO_BYTE) |=>
      ((hist.history & $past(hist.history)) == $past(hist.history));
  endproperty
  a_noSelfClear: assert property (p_noSelfClear)
    else $error("history bit cleared without software");

  property p_freshProtect;
    @(posedge clock) disable iff (sys_rst)
    (clockEnable && hist.writeStrobe && hist.hwClear == ZERO_BYTE) |=>
      ((hist.history & $past(fresh)) ==
       ($past(hist.history) & $past(fresh)));
  endproperty
  a_freshProtect: assert property (p_freshProtect)
    else $error("unread history bit cleared by write");

  property p_writeOneKeeps;
    @(posedge clock) disable iff (sys_rst)
    (clockEnable && hist.writeStrobe && hist.hwClear == ZERO_BYTE) |=>
      ((hist.history & $past(hist.writeData)) ==
       ($past(hist.history) & $past(hist.writeData)));
  endproperty
  a_writeOneKeeps: assert property (p_writeOneKeeps)
    else $error("writing one changed a history bit");

endmodule : line_state_history
`default_nettype wire

// *** verif/line_state_condition_latch_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin errCount++; \
  $display("wrong value at %0t: %h not %h", $time, g, e); end end
module line_state_condition_latch_tb;
  import line_state_pkg::*;
  logic clock = 1'b0;
  logic sysRst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready;
  logic rvalid, interruptRequest;
  logic [ADDR_W-1:0] awaddr = 8'h00, araddr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp, resp;
  logic [4:0] cond = 5'h00;
  logic noiseCounterZero = 1'b0;
  logic [REG_W-1:0] historyBEvents = 8'h00, noiseThreshold, expA;
  logic [REG_W-1:0] noisePre;
  logic ce = 1'b1, otherKnown = 1'b0;
  logic [STRB_W-1:0] wstrb = 4'hF;
  int errCount = 0, cmpCount = 0;
  line_state_condition_latch dut (
    .clock, .sys_rst(sysRst), .clockEnable(ce), .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .signal_detect_input(!cond[0]), .quietDetect(cond[1]),
    .haltDetect(cond[2]), .masterDetect(cond[3]), .noiseDetect(cond[4]),
    .otherKnownDetect(otherKnown), .noiseCounterZero, .historyBEvents,
    .noiseThreshold, .noisePrescaleThreshold(noisePre), .interruptRequest
  );
  // ****************
  // Bus master tasks
  // ****************
  task automatic wr(input reg_index_t i, input logic [7:0] d);
    @(posedge clock);
    awaddr <= {i, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rc(input reg_index_t i, input logic [7:0] e,
    input logic [1:0] er);
    @(posedge clock);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
    `CHK(rdata, {24'h000000, e})
    `CHK(rresp, er)
  endtask : rc
  task automatic closeOut();
    $display("Mismatches %0d, comparisons %0d", errCount, cmpCount);
    if (errCount == 0 && cmpCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : closeOut
  initial
  begin
    forever #5 clock = ~clock;
  end
  // Far beyond the roughly two hundred cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge clock);
    errCount++;
    closeOut();
  end
  initial
  begin
    repeat (8) @(posedge clock);
    sysRst <= 1'b0;
    rc(IDX_HIST_A, 8'h20, RESP_OKAY);
    rc(IDX_HIST_B, 8'h00, RESP_OKAY);
    rc(6'h01, 8'h00, RESP_SLVERR);
    wr(6'h3F, 8'h55);
    `CHK(resp, RESP_SLVERR)
    expA = 8'h20;
    for (int k = 0; k < 5; k++)
    begin
      cond <= 5'(1 << k);
      repeat (3) @(posedge clock);
      cond <= 5'h00;
      repeat (3) @(posedge clock);
      expA = expA | 8'hC0 | 8'(1 << k);
      rc(IDX_HIST_A, expA, RESP_OKAY);
    end
    wr(IDX_NOISE_THR, 8'h01);
    `CHK(noiseThreshold, 8'h01)
    rc(IDX_HIST_A, 8'hDF, RESP_OKAY);
    noiseCounterZero <= 1'b1;
    repeat (2) @(posedge clock);
    noiseCounterZero <= 1'b0;
    rc(IDX_HIST_A, 8'hFF, RESP_OKAY);
    wr(IDX_HIST_A, 8'h00);
    rc(IDX_HIST_A, 8'h20, RESP_OKAY);
    // A set after the last read must survive a write of zero
    cond <= 5'h02;
    wr(IDX_HIST_A, 8'h00);
    rc(IDX_HIST_A, 8'h62, RESP_OKAY);
    historyBEvents <= 8'h08;
    @(posedge clock);
    historyBEvents <= 8'h00;
    rc(IDX_HIST_B, 8'h08, RESP_OKAY);
    wr(IDX_MASK_A, 8'h02);
    rc(IDX_SUMMARY, 8'h01, RESP_OKAY);
    wr(IDX_MASK_B, 8'h08);
    wr(IDX_IRQ_MASK, 8'h03);
    rc(IDX_SUMMARY, 8'h03, RESP_OKAY);
    `CHK(interruptRequest, 1'b1)
    wr(IDX_MASK_A, 8'h00);
    wr(IDX_MASK_B, 8'h00);
    rc(IDX_SUMMARY, 8'h00, RESP_OKAY);
    wr(IDX_IRQ_STATUS, 8'h03);
    `CHK(interruptRequest, 1'b0)
    // A zero prescale load must not rearm the expiry flag
    wr(IDX_NOISE_PRE, 8'h00);
    rc(IDX_HIST_A, 8'h62, RESP_OKAY);
    wr(IDX_NOISE_PRE, 8'h03);
    `CHK(noisePre, 8'h03)
    rc(IDX_HIST_A, 8'h42, RESP_OKAY);
    wstrb <= 4'h0;
    wr(IDX_MASK_A, 8'hFF);
    `CHK(resp, RESP_OKAY)
    wstrb <= 4'hF;
    rc(IDX_MASK_A, 8'h00, RESP_OKAY);
    // Unknown after a non-invalidating known state: change only
    wr(IDX_HIST_A, 8'h00);
    cond <= 5'h00;
    otherKnown <= 1'b1;
    repeat (3) @(posedge clock);
    otherKnown <= 1'b0;
    repeat (3) @(posedge clock);
    rc(IDX_HIST_A, 8'h40, RESP_OKAY);
    // An event while frozen is not recorded
    ce <= 1'b0;
    historyBEvents <= 8'h01;
    @(posedge clock);
    historyBEvents <= 8'h00;
    ce <= 1'b1;
    rc(IDX_HIST_B, 8'h08, RESP_OKAY);
    closeOut();
  end
endmodule : line_state_condition_latch_tb
`default_nettype wire
